// ==== design/sap_pkg.sv ====
// package for the simultaneous-sampling converter host port
// assumes a 20 MHz system clock and a strobe-driven host outside it
package sap_pkg;
	localparam int CLK_MHZ = 20;
	localparam int CONV_TIME_NS = 3000;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	// longest time rounds down
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int RES_W = 16;
	localparam int CFG_W = 4;
	localparam int CNT_W = 8;
	localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
	localparam int CFG_TRIG_POS = 0;
	localparam int CFG_RSVD_POS = 1;
	localparam int CFG_FMT_POS = 2;
	localparam int CFG_REF_POS = 3;
	localparam int FIFO_DEPTH = 8;
	// pins at rest: strobes high, trigger and power-down low
	localparam logic [4:0] PIN_IDLE = 5'h07;
	localparam logic [RES_W-1:0] SIGN_MASK16 = 16'h8000;
	localparam logic [RES_W-1:0] SIGN_MASK14 = 16'h2000;

	typedef struct packed {
		logic ref_source_bit;
		logic result_format_bit;
		logic reserved_zero_bit;
		logic trigger_mode_bit;
	} sap_cfg_t;

	typedef struct packed {
		logic [CH_W-1:0] ch;
		logic [RES_W-1:0] value;
	} sap_word_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ = 2'b01,
		ST_CONV = 2'b10,
		ST_DOWN = 2'b11
	} sap_state_t;
endpackage : sap_pkg

// ==== design/sap_fifo.sv ====
// small flip-flop fifo, valid/ready on both sides
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ps
module sap_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= AW'((wp_r + 1'b1) % DEPTH);
			if (pop)
				rp_r <= AW'((rp_r + 1'b1) % DEPTH);
			cnt_r <= (AW+1)'(cnt_r + push - pop);
		end
	end
endmodule : sap_fifo

// ==== design/sap_top.sv ====
// digital control and parallel host port of the simultaneous-sampling converter
// assumes host strobes and trigger arrive asynchronously; sample words come from sar cores
`timescale 1ns/1ps
module sap_top
	import sap_pkg::*;
#(
	parameter bit IS_14BIT = 1'b0
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// host strobes, trigger and power-down
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic SAMPLE_END_TRIGGER,
	input wire logic POWER_DOWN_IN,
	// result bus, three-signal form
	input wire logic [RES_W-1:0] RESULT_BUS_I,
	output logic [RES_W-1:0] RESULT_BUS_O,
	output logic [RES_W-1:0] RESULT_BUS_OE,
	// dedicated config pins of the narrow variant
	input wire logic CFG_PIN_1,
	input wire logic CFG_PIN_0,
	// converter cores
	input wire logic [NUM_CH*RES_W-1:0] SAR_RESULTS,
	output logic SAR_SAMPLE,
	output logic SAR_CONVERT,
	output logic LOW_POWER,
	// status and config outputs
	output logic CONV_DONE_N,
	output logic REF_SOURCE_BIT,
	output logic RESULT_FORMAT_BIT,
	output logic TRIGGER_MODE_BIT
);
	// How it works
	// RULE_01: done flag high at start, low after
	// RULE_02: trigger rise ends sampling, starts converting
	// RULE_03: mode 0 acquires while trigger low
	// RULE_04: power-down high holds low-current state
	// RULE_05: config survives power-down
	// RULE_06: config loads on write strobe rise
	// RULE_07: host holds chip select for accesses
	// RULE_08: read strobe rise advances channel
	// RULE_09: all channels convert together
	// RULE_10: results ready fixed time after sampling
	// RULE_11: wide variant config on lines 3-0
	// RULE_12: narrow variant config lines 1-0 plus pins
	// RULE_13: result width 16 or 14 lines
	// RULE_14: host shares bus for config writes
	// RULE_15: bus released when read or select high
	// RULE_16: mode 1 reacquires after conversion ends
	// RULE_17: format bit picks offset or twos complement
	// RULE_18: reference bit, reserved bit kept zero
	// RULE_19: readout restarts at channel 0
	// RULE_20: results held until next conversion

	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic [4:0] s3_r;
	logic [RES_W-1:0] bus1_r;
	logic [RES_W-1:0] bus2_r;
	logic [1:0] pin1_r;
	logic [1:0] pin2_r;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic trig;
	logic pdn;
	logic trig_rise;
	logic rd_rise;
	logic wr_rise;
	sap_cfg_t cfg_r;
	sap_cfg_t cfg_nxt;
	sap_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [RES_W-1:0] res_r [NUM_CH];
	logic [CH_W-1:0] ptr_r;
	logic done_n_r;
	logic [RES_W-1:0] bus_o_r;
	logic [RES_W-1:0] bus_oe_r;
	logic conv_end;
	logic fifo_in_valid;
	logic fifo_in_ready;
	sap_word_t fifo_in;
	logic fifo_out_valid;
	sap_word_t fifo_out;
	logic [CH_W-1:0] load_ch_r;
	logic loading_r;
	logic [RES_W-1:0] fmt_word;
	logic [RES_W-1:0] raw_word;
	logic [RES_W-1:0] sign_mask;

	// two-stage synchronisers for every pin input
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			// rest levels, so no false power-down or edge after reset
			s1_r <= PIN_IDLE;
			s2_r <= PIN_IDLE;
			s3_r <= PIN_IDLE;
			bus1_r <= '0;
			bus2_r <= '0;
			pin1_r <= '0;
			pin2_r <= '0;
		end
		else
		begin
			s1_r <= {POWER_DOWN_IN, SAMPLE_END_TRIGGER, WR_N, RD_N, CS_N};
			s2_r <= s1_r;
			s3_r <= s2_r;
			bus1_r <= RESULT_BUS_I;
			bus2_r <= bus1_r;
			pin1_r <= {CFG_PIN_1, CFG_PIN_0};
			pin2_r <= pin1_r;
		end
	end

	assign cs_n = s2_r[0];
	assign rd_n = s2_r[1];
	assign wr_n = s2_r[2];
	assign trig = s2_r[3];
	assign pdn = s2_r[4];
	assign trig_rise = trig && !s3_r[3];
	// select taken one stage back: host may lift select with the strobe
	assign rd_rise = rd_n && !s3_r[1] && !s3_r[0];
	// data taken from the same sync stage as the strobe; select taken one stage back
	assign wr_rise = wr_n && !s3_r[2] && !s3_r[0];

	// RULE_11 RULE_12 config routing per variant
	always_comb
	begin
		cfg_nxt = cfg_r;
		if (IS_14BIT)
			cfg_nxt = sap_cfg_t'({bus2_r[1:0], pin2_r});
		else
			cfg_nxt = sap_cfg_t'(bus2_r[3:0]);
		// RULE_18 reserved bit forced zero
		cfg_nxt.reserved_zero_bit = 1'b0;
	end

	// RULE_06 RULE_05 load on write rise, power-down leaves it
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			cfg_r <= sap_cfg_t'(CFG_RESET);
		else if (wr_rise)
			cfg_r <= cfg_nxt;
	end

	assign conv_end = (state_r == ST_CONV) && (cnt_r == CNT_W'(CONV_CYCLES - 1));

	// RULE_02 RULE_03 RULE_16 RULE_04 sequencing
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
		end
		else if (pdn)
			state_r <= ST_DOWN;
		else
		begin
			unique case (state_r)
				ST_DOWN:
					state_r <= ST_IDLE;
				ST_IDLE:
					if (trig_rise)
					begin
						state_r <= ST_CONV;
						cnt_r <= '0;
					end
					else if (!trig)
						state_r <= ST_ACQ;
				ST_ACQ:
					if (trig_rise)
					begin
						state_r <= ST_CONV;
						cnt_r <= '0;
					end
				ST_CONV:
					// RULE_10 fixed conversion time
					if (conv_end)
						state_r <= cfg_r.trigger_mode_bit ? ST_ACQ : ST_IDLE;
					else
						cnt_r <= CNT_W'(cnt_r + 1'b1);
			endcase
		end
	end

	// RULE_01 done flag
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			done_n_r <= 1'b1;
		else if (state_r != ST_CONV && trig_rise && !pdn)
			done_n_r <= 1'b1;
		else if (conv_end && !pdn)
			done_n_r <= 1'b0;
	end

	// RULE_09 core results taken one channel per clock after conversion end; queued through fifo
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			loading_r <= 1'b0;
			load_ch_r <= '0;
		end
		else if (conv_end && !pdn)
		begin
			loading_r <= 1'b1;
			load_ch_r <= '0;
		end
		else if (loading_r && fifo_in_ready)
		begin
			load_ch_r <= CH_W'(load_ch_r + 1'b1);
			if (load_ch_r == CH_W'(NUM_CH - 1))
				loading_r <= 1'b0;
		end
	end

	assign raw_word = SAR_RESULTS[load_ch_r*RES_W +: RES_W];
	assign sign_mask = IS_14BIT ? SIGN_MASK14 : SIGN_MASK16;
	// RULE_17 RULE_13 format and width
	assign fmt_word = (cfg_r.result_format_bit ? (raw_word ^ sign_mask) : raw_word)
		& (IS_14BIT ? 16'h3fff : 16'hffff);
	assign fifo_in_valid = loading_r;
	assign fifo_in = '{ch: load_ch_r, value: fmt_word};

	sap_fifo #(.WIDTH($bits(sap_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.nrst(NRST),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1),
		.out_data(fifo_out)
	);

	// RULE_20 results held until overwritten
	generate
		for (genvar g = 0; g < NUM_CH; g++)
		begin : g_res
			always_ff @(posedge CLK)
			begin
				if (!NRST)
					res_r[g] <= '0;
				else if (fifo_out_valid && fifo_out.ch == CH_W'(g))
					res_r[g] <= fifo_out.value;
			end
		end
	endgenerate

	// RULE_19 RULE_08 readout pointer
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			ptr_r <= '0;
		else if (conv_end)
			ptr_r <= '0;
		else if (rd_rise)
			ptr_r <= CH_W'((ptr_r + 1'b1) % NUM_CH);
	end

	// RULE_15 bus driven only with read and select low
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			bus_o_r <= '0;
			bus_oe_r <= '0;
		end
		else
		begin
			bus_o_r <= res_r[ptr_r];
			bus_oe_r <= (!rd_n && !cs_n && !pdn) ? (IS_14BIT ? 16'h3fff : 16'hffff) : 16'h0000;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			SAR_SAMPLE <= 1'b0;
			SAR_CONVERT <= 1'b0;
			LOW_POWER <= 1'b0;
		end
		else
		begin
			SAR_SAMPLE <= (state_r == ST_ACQ);
			SAR_CONVERT <= (state_r == ST_CONV);
			LOW_POWER <= pdn;
		end
	end

	assign RESULT_BUS_O = bus_o_r;
	assign RESULT_BUS_OE = bus_oe_r;
	assign CONV_DONE_N = done_n_r;
	assign REF_SOURCE_BIT = cfg_r.ref_source_bit;
	assign RESULT_FORMAT_BIT = cfg_r.result_format_bit;
	assign TRIGGER_MODE_BIT = cfg_r.trigger_mode_bit;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	conv_time_a: assert property (trig_rise && state_r == ST_ACQ && !pdn ##1 !pdn [*8]
		|-> state_r == ST_CONV) // RULE_02
		else $error("trigger did not start conversion");
	done_high_a: assert property (state_r == ST_ACQ && trig_rise && !pdn |=> done_n_r) // RULE_01
		else $error("done flag not raised at start");
	done_low_a: assert property (conv_end && !pdn |=> !done_n_r) // RULE_01
		else $error("done flag not lowered at end");
	mode_zero_a: assert property (state_r == ST_CONV && conv_end && !cfg_r.trigger_mode_bit
		&& !pdn |=> state_r == ST_IDLE) // RULE_03
		else $error("mode 0 reacquired without trigger");
	mode_one_a: assert property (conv_end && cfg_r.trigger_mode_bit && !pdn
		|=> state_r == ST_ACQ) // RULE_16
		else $error("mode 1 did not reacquire");
	pdn_state_a: assert property (pdn |=> state_r == ST_DOWN) // RULE_04
		else $error("power-down not entered");
	cfg_keep_a: assert property (!wr_rise |=> cfg_r == $past(cfg_r)) // RULE_05
		else $error("config changed without write");
	bus_float_a: assert property ((rd_n || cs_n) |=> bus_oe_r == '0) // RULE_15
		else $error("bus driven while deselected");
	ptr_adv_a: assert property (rd_rise && !conv_end
		|=> ptr_r == CH_W'(($past(ptr_r) + 1) % NUM_CH)) // RULE_08
		else $error("pointer did not advance");
	ptr_zero_a: assert property (conv_end |=> ptr_r == '0) // RULE_19
		else $error("pointer not restarted");
	rsvd_zero_a: assert property (cfg_r.reserved_zero_bit == 1'b0) // RULE_18
		else $error("reserved bit set");
	conv_len_a: assert property ($rose(state_r == ST_CONV) && !pdn ##1 !pdn [*8]
		|-> state_r == ST_CONV) // RULE_10
		else $error("conversion too short");

	conv_c: cover property (conv_end ##[1:20] fifo_out_valid);
	read_c: cover property (rd_rise);
	write_c: cover property (wr_rise);
	pdn_c: cover property (state_r == ST_DOWN ##1 state_r == ST_IDLE);
endmodule : sap_top

// ==== bench/sap_host.sv ====
// host model: strobes and config data on the shared bus
// assumes sap_top pins; levels change just after a rising edge
`timescale 1ns/1ps
module sap_host
	import sap_pkg::*;
(
	// clock
	input wire logic clk,
	// strobes
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	// bus
	input wire logic [RES_W-1:0] bus_i,
	output logic [RES_W-1:0] bus_o,
	output logic bus_oe
);
	initial
	begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		bus_o = '0;
		bus_oe = 1'b0;
	end
	// strobes are oversampled, so each level is held 4 clocks or more
	task write_cfg(input logic [RES_W-1:0] v);
		cs_n <= 1'b0;
		bus_oe <= 1'b1;
		bus_o <= v;
		wr_n <= 1'b0;
		repeat (4) @(posedge clk);
		wr_n <= 1'b1;
		repeat (4) @(posedge clk);
		bus_oe <= 1'b0;
		cs_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : write_cfg
	task read_word(output logic [RES_W-1:0] v);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (5) @(posedge clk);
		v = bus_i;
		rd_n <= 1'b1;
		cs_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask : read_word
endmodule : sap_host

// ==== bench/tb_sap_top.sv ====
// self-checking bench for the converter host port and its fifo
// assumes sap_host drives strobes; bus level resolved here
`timescale 1ns/1ps
module tb_sap_top
	import sap_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic trig = 1'b0;
	logic pdn = 1'b0;
	logic noise = 1'b0;
	logic [NUM_CH*RES_W-1:0] sar = '0;
	logic [15:0] bus, bo, boe, h_o, rd_v;
	logic done_n, ref_b, fmt_b, trig_b, samp, conv, lowp;
	logic h_cs, h_rd, h_wr, h_oe;
	logic [3:0] cfg;
	int bad_count = 0;
	int n_tests = 0;
	int seed = 32'h00094eab;
	int i, k, n;
	always #25 clk = ~clk;
	// undriven lines toggle so a stale value cannot pass
	always @(posedge clk) noise <= ~noise;
	assign bus = (boe & bo) | (~boe & (h_oe ? h_o : {16{noise}}));
	sap_top #(.IS_14BIT(1'b0)) u_sap_top (.CLK(clk), .NRST(nrst), .CS_N(h_cs),
		.RD_N(h_rd), .WR_N(h_wr), .SAMPLE_END_TRIGGER(trig), .POWER_DOWN_IN(pdn),
		.RESULT_BUS_I(bus), .RESULT_BUS_O(bo), .RESULT_BUS_OE(boe), .CFG_PIN_1(1'b0),
		.CFG_PIN_0(1'b0), .SAR_RESULTS(sar), .SAR_SAMPLE(samp), .SAR_CONVERT(conv),
		.LOW_POWER(lowp), .CONV_DONE_N(done_n), .REF_SOURCE_BIT(ref_b),
		.RESULT_FORMAT_BIT(fmt_b), .TRIGGER_MODE_BIT(trig_b));
	sap_host u_sap_host (.clk(clk), .cs_n(h_cs), .rd_n(h_rd), .wr_n(h_wr),
		.bus_i(bus), .bus_o(h_o), .bus_oe(h_oe));
	function logic [15:0] exp_word(input logic [15:0] raw, input logic fmt);
		return fmt ? raw ^ SIGN_MASK16 : raw;
	endfunction : exp_word
	task complete_run;
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	// bounded wait for the done flag; running out counts as a mismatch
	task wait_done(output int cyc);
		cyc = 0;
		while (done_n !== 1'b0 && cyc < 300)
		begin
			@(posedge clk);
			cyc++;
		end
		if (cyc >= 300)
		begin
			bad_count++;
			$display("unexpected at %0t: conversion never finished", $time);
			complete_run();
		end
	endtask : wait_done
	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		chk({12'h0, done_n, ref_b, fmt_b, trig_b}, 16'h0008, "reset");
		chk(boe, 16'h0000, "idle bus");
		for (k = 0; k < 4; k++)
		begin
			cfg = 4'($random(seed)) & 4'hd;
			u_sap_host.write_cfg({12'h0, cfg});
			chk({12'h0, ref_b, fmt_b, 1'b0, trig_b}, {12'h0, cfg}, "config");
			sar <= {$random(seed), $random(seed), $random(seed), $random(seed)};
			trig <= 1'b0;
			repeat (30) @(posedge clk);
			chk({15'h0, samp}, 16'h1, "acquire");
			trig <= 1'b1;
			repeat (6) @(posedge clk);
			chk({14'h0, conv, done_n}, 16'h3, "converting");
			wait_done(n);
			// two sync stages, edge stage, count, done register
			chk(16'(n + 6), 16'(CONV_CYCLES + 4), "conv time");
			repeat (20) @(posedge clk);
			chk({15'h0, samp}, {15'h0, cfg[0]}, "reacquire");
			// ninth read wraps back to channel 0
			for (i = 0; i < 9; i++)
			begin
				u_sap_host.read_word(rd_v);
				chk(rd_v, exp_word(sar[(i%8)*16 +: 16], cfg[2]), "result");
			end
			chk(boe, 16'h0000, "released");
		end
		pdn <= 1'b1;
		repeat (8) @(posedge clk);
		chk({15'h0, lowp}, 16'h1, "power down");
		pdn <= 1'b0;
		repeat (8) @(posedge clk);
		chk({13'h0, ref_b, fmt_b, trig_b}, {13'h0, cfg[3:2], cfg[0]}, "kept");
		// conversion after wake-up, results queued through the fifo, read twice
		sar <= {$random(seed), $random(seed), $random(seed), $random(seed)};
		trig <= 1'b0;
		repeat (30) @(posedge clk);
		trig <= 1'b1;
		repeat (6) @(posedge clk);
		wait_done(n);
		chk(16'(n + 6), 16'(CONV_CYCLES + 4), "wake conv");
		repeat (20) @(posedge clk);
		for (i = 0; i < 16; i++)
		begin
			u_sap_host.read_word(rd_v);
			chk(rd_v, exp_word(sar[(i%8)*16 +: 16], cfg[2]), "held result");
		end
		chk(boe, 16'h0000, "drained");
		chk({15'h0, done_n}, 16'h0, "done stands");
		complete_run();
	end
endmodule : tb_sap_top
